// [adc_serial_port.sv]
// Serial result and select port of a multichannel converter
`timescale 1ns/1ps

module adc_serial_port (
   // Core clock and reset
   input  wire logic            core_clk,
   input  wire logic            srst,
   // Serial link
   input  wire logic            sck,
   input  wire logic            cs_n,
   input  wire logic            sdi,
   output logic                 serial_result_out,
   output logic                 serial_result_oe,
   // Converter core
   input  wire logic            conv_done,
   input  wire adc_pkg::result_t conv_result,
   output logic                 conv_start_q,
   output logic                 conv_busy_q,
   output logic [2:0]           pos_input_q,
   output logic [2:0]           neg_input_q,
   output logic [15:0]          osr_ratio_q,
   output logic                 double_rate_q
);

   // Gray to binary for the crossed edge count
   function automatic logic [adc_pkg::CNT_W-1:0] gray2bin(
      input logic [adc_pkg::CNT_W-1:0] g);
      logic [adc_pkg::CNT_W-1:0] b;
      b[adc_pkg::CNT_W-1] = g[adc_pkg::CNT_W-1];
      for (int i = adc_pkg::CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // Oversampling code to ratio, doubling from the base
   function automatic logic [15:0] osr_of(input logic [3:0] code);
      logic [15:0] r;
      r = adc_pkg::OSR_BASE << code;
      if (code == adc_pkg::OSR_MAXCODE) begin
         r = adc_pkg::OSR_MAX;
      end else if (code > adc_pkg::OSR_LASTPOW) begin
         r = adc_pkg::OSR_MAX;
      end
      return r;
   endfunction

   // ---------------- Link domain on sck ----------------
   logic [adc_pkg::CNT_W-1:0] edge_cnt_q;
   logic [adc_pkg::CNT_W-1:0] edge_gray_q;
   logic [adc_pkg::CFG_BITS-1:0] cfg_shift_q;
   wire  [adc_pkg::CNT_W-1:0] edge_cnt_d = edge_cnt_q + 5'h01;

   // The clock stops between frames, so chip select ends the frame itself
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         edge_cnt_q  <= '0;
         edge_gray_q <= '0;
      end else begin
         edge_cnt_q  <= edge_cnt_d;
         edge_gray_q <= edge_cnt_d ^ (edge_cnt_d >> 1);
      end
   end

   // Control word sampled on the first rising edges of a frame
   always_ff @(posedge sck) begin
      if (!cs_n && (edge_cnt_q < 5'(adc_pkg::CFG_BITS))) begin
         cfg_shift_q <= {cfg_shift_q[adc_pkg::CFG_BITS-2:0], sdi};
      end
   end

   // ---------------- Crossings into the core domain ----------------
   // Select is crossed true-high so the synchroniser's reset reads idle
   logic                         cs_sel_s;
   wire                          cs_n_s = !cs_sel_s;
   logic [adc_pkg::CNT_W-1:0]    gray_s;
   logic [adc_pkg::CFG_BITS-1:0] cfg_raw_s;

   sync3 #(.WIDTH(1)) u_cs_sync (
      .clk  (core_clk),
      .srst (srst),
      .din  (!cs_n),
      .dout (cs_sel_s)
   );

   sync3 #(.WIDTH(adc_pkg::CNT_W)) u_cnt_sync (
      .clk  (core_clk),
      .srst (srst),
      .din  (edge_gray_q),
      .dout (gray_s)
   );

   // Word is quasi-static: untouched after its last bit until next frame
   sync3 #(.WIDTH(adc_pkg::CFG_BITS)) u_cfg_sync (
      .clk  (core_clk),
      .srst (srst),
      .din  (cfg_shift_q),
      .dout (cfg_raw_s)
   );

   // ---------------- Core domain ----------------
   adc_pkg::state_t state_q;
   logic [adc_pkg::CNT_W-1:0] cnt_prev_q;
   logic                      cs_prev_q;
   logic                      eoc_n_q;
   logic                      boot_q;
   logic                      cfg_ready_q;
   logic [adc_pkg::WORD_W-1:0] word_q;
   adc_pkg::cfg_t             cur_cfg_q;

   // Decode of link events
   wire [adc_pkg::CNT_W-1:0] cnt_s = gray2bin(gray_s);
   wire adc_pkg::cfg_t new_cfg = adc_pkg::cfg_t'(cfg_raw_s[9:0]);
   wire [2:0] prefix = cfg_raw_s[12:10];
   wire in_sleep  = (state_q == adc_pkg::ST_SLEEP);
   wire in_output = (state_q == adc_pkg::ST_OUTPUT);
   wire in_conv   = (state_q == adc_pkg::ST_CONVERT);
   wire first_edge = in_sleep && !cs_n_s && (cnt_s != '0);
   wire wrap_done = in_output && !cs_n_s
                    && (cnt_prev_q == adc_pkg::LAST_BIT) && (cnt_s == '0);
   wire abort = in_output && cs_n_s && !cs_prev_q;
   wire start = boot_q || wrap_done || abort;
   wire apply_cfg = cfg_ready_q && (prefix == adc_pkg::PREFIX_UPDATE);
   wire apply_osr = apply_cfg
                    && (new_cfg.oversample_code != adc_pkg::OSR_KEEP);
   wire capture = in_conv && conv_done && !boot_q;

   // Channel field decode: pair chosen by the lowest address bit
   wire [2:0] dec_pos = {1'b0, new_cfg.pair_select, new_cfg.odd_polarity};
   wire [2:0] dec_neg = new_cfg.single_ended_select ? adc_pkg::COM_SEL
                        : {1'b0, new_cfg.pair_select,
                           ~new_cfg.odd_polarity};

   // Output bit: data while reading, else the done flag
   wire sdo_d = in_output ? word_q[~cnt_s] : eoc_n_q;

   // Conversion sequence
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= adc_pkg::ST_CONVERT;
      end else if (start) begin
         state_q <= adc_pkg::ST_CONVERT;
      end else if (capture) begin
         state_q <= adc_pkg::ST_SLEEP;
      end else if (first_edge) begin
         state_q <= adc_pkg::ST_OUTPUT;
      end
   end

   // Done flag follows the conversion, not the serial clock
   always_ff @(posedge core_clk) begin
      if (srst) begin
         eoc_n_q <= 1'b1;
      end else if (start) begin
         eoc_n_q <= 1'b1;
      end else if (capture) begin
         eoc_n_q <= 1'b0;
      end
   end

   // Result word, held until the next conversion ends
   always_ff @(posedge core_clk) begin
      if (srst) begin
         word_q <= '0;
      end else if (capture) begin
         word_q <= {1'b0, adc_pkg::FILLER_VALUE, conv_result};
      end
   end

   // Edge history and control word readiness
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_prev_q  <= '0;
         cs_prev_q   <= 1'b1;
         boot_q      <= 1'b1;
         cfg_ready_q <= 1'b0;
      end else begin
         cnt_prev_q <= cnt_s;
         cs_prev_q  <= cs_n_s;
         boot_q     <= 1'b0;
         if (start) begin
            cfg_ready_q <= 1'b0;
         end else if (in_output
                      && (cnt_s >= 5'(adc_pkg::CFG_DONE_CNT))) begin
            cfg_ready_q <= 1'b1;
         end
      end
   end

   // Settings for the next conversion, taken at its start
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cur_cfg_q   <= '0;
         pos_input_q <= 3'h0;
         neg_input_q <= 3'h1;
         cur_cfg_q.oversample_code <= adc_pkg::OSR_RESET;
      end else if (start && apply_cfg) begin
         cur_cfg_q.single_ended_select <= new_cfg.single_ended_select;
         cur_cfg_q.odd_polarity <= new_cfg.odd_polarity;
         cur_cfg_q.pair_select  <= new_cfg.pair_select;
         pos_input_q <= dec_pos;
         neg_input_q <= dec_neg;
         if (apply_osr) begin
            cur_cfg_q.oversample_code <= new_cfg.oversample_code;
            cur_cfg_q.double_rate     <= new_cfg.double_rate;
         end
      end
   end

   // Ratio and rate outputs track the held settings
   always_ff @(posedge core_clk) begin
      if (srst) begin
         osr_ratio_q   <= osr_of(adc_pkg::OSR_RESET);
         double_rate_q <= 1'b0;
      end else begin
         osr_ratio_q   <= osr_of(cur_cfg_q.oversample_code);
         double_rate_q <= cur_cfg_q.double_rate;
      end
   end

   // Start pulse and busy level toward the converter core
   always_ff @(posedge core_clk) begin
      if (srst) begin
         conv_start_q <= 1'b0;
         conv_busy_q  <= 1'b1;
      end else begin
         conv_start_q <= start;
         conv_busy_q  <= start || (in_conv && !capture);
      end
   end

   // Pin drive; released whenever chip select is high
   always_ff @(posedge core_clk) begin
      if (srst) begin
         serial_result_out <= 1'b1;
         serial_result_oe  <= 1'b0;
      end else begin
         serial_result_out <= sdo_d;
         serial_result_oe  <= !cs_n_s;
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   oe_release_a: assert property ($rose(cs_n_s) |=> !serial_result_oe)
      else $error("output driven with chip select high");
   done_low_a: assert property (capture && !cs_n_s |-> ##2 !serial_result_out)
      else $error("done flag not low after conversion");
   busy_high_a: assert property (start |=> eoc_n_q [*2])
      else $error("done flag not high during conversion");
   sleep_wait_a: assert property (in_sleep && (cs_n_s || cnt_s == '0) && !start
                                  |=> !in_output)
      else $error("left sleep without a clock edge");
   enter_out_a: assert property (first_edge && !start |=> in_output)
      else $error("first edge did not start output");
   abort_start_a: assert property (abort |=> conv_start_q && in_conv)
      else $error("abort did not restart conversion");
   msb_first_a: assert property (in_output && cnt_s == 5'h01 |=>
                                 serial_result_out == $past(word_q[30]))
      else $error("wrong bit order");
   word_head_a: assert property (capture |=> word_q[31:30] == 2'b00
                                 && word_q[29] == $past(conv_result.sign_bit))
      else $error("bad word header");
   keep_speed_a: assert property (start && !apply_osr |=>
                                  $stable(cur_cfg_q.oversample_code))
      else $error("speed changed without update");
   keep_chan_a: assert property (start && !apply_cfg |=> $stable(pos_input_q)
                                 && $stable(neg_input_q))
      else $error("channel changed without prefix");
   com_return_a: assert property (start && apply_cfg
                                  && new_cfg.single_ended_select
                                  |=> neg_input_q == 3'h4)
      else $error("single-ended not against common");
   osr_map_a: assert property (cur_cfg_q.oversample_code == 4'h3 |=>
                               osr_ratio_q == 16'h0100)
      else $error("wrong ratio mapping");

   oe_drive_a: assert property ($fell(cs_n_s) |=> serial_result_oe)
      else $error("output not driven with chip select low");
   rate_track_a: assert property (
      cur_cfg_q.double_rate |=> double_rate_q)
      else $error("double rate not following setting");

   read_cover_c:  cover property (first_edge ##[1:400] wrap_done);
   sleep_cover_c: cover property (capture && !cs_n_s);
   abort_cover_c: cover property (abort);
   update_cover_c: cover property (start && apply_osr);
endmodule

// [adc_sync.sv]
// Shared constants and types, plus the cross-domain synchroniser
`timescale 1ns/1ps

package adc_pkg;
   localparam int WORD_W       = 32;
   localparam int CNT_W        = 5;
   localparam int CFG_BITS     = 13;
   localparam int CFG_DONE_CNT = 14;
   localparam logic [2:0] PREFIX_UPDATE = 3'h5;
   localparam logic [3:0] OSR_KEEP      = 4'h0;
   localparam logic [3:0] OSR_RESET     = 4'h3;
   localparam logic [3:0] OSR_MAXCODE   = 4'hf;
   localparam logic [3:0] OSR_LASTPOW   = 4'h9;
   localparam logic [15:0] OSR_BASE     = 16'h0020;
   localparam logic [15:0] OSR_MAX      = 16'h8000;
   localparam logic [2:0] COM_SEL       = 3'h4;
   localparam logic [4:0] LAST_BIT      = 5'h1f;
   localparam logic       FILLER_VALUE  = 1'b0;

   // Channel and speed word as shifted in after the prefix
   typedef struct packed {
      logic       single_ended_select;
      logic       odd_polarity;
      logic       unused_addr_high;
      logic       unused_addr_low;
      logic       pair_select;
      logic [3:0] oversample_code;
      logic       double_rate;
   } cfg_t;

   // Result handed over by the converter core
   typedef struct packed {
      logic        sign_bit;
      logic [23:0] data;
      logic [4:0]  sub_lsb;
   } result_t;

   typedef enum logic [2:0] {
      ST_CONVERT = 3'h1,
      ST_SLEEP   = 3'h2,
      ST_OUTPUT  = 3'h4
   } state_t;
endpackage

// Three-stage synchroniser; the output follows once stages two and three agree
module sync3 #(
   parameter int WIDTH = 1
) (
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   wire              agree = (s2_q == s3_q);

   // Stage one is read only by stage two
   always_ff @(posedge clk) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // Accept a value only once it is stable
   always_ff @(posedge clk) begin
      if (srst) begin
         dout <= '0;
      end else if (agree) begin
         dout <= s3_q;
      end
   end
endmodule

// [spi_host_model.sv]
// SPI host model that drives the converter's serial port pins
`timescale 1ns/1ps
module spi_host_model (
   // Link pins
   output logic      cs_n,
   output logic      sck,
   output logic      sdi,
   input  wire logic serial_result_out,
   input  wire logic serial_result_oe
);
   logic last_q;
   logic line;

   // A released output shows the inverse of its last level, never a guess
   always @(serial_result_out or serial_result_oe)
      if (serial_result_oe) last_q = serial_result_out;
   assign line = serial_result_oe ? serial_result_out : ~last_q;

   // Idle pins: deselected, link clock parked low
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
      last_q = 1'b0;
   end

   // Chip select alone, used to watch the done flag
   task automatic select(input logic on);
      cs_n = ~on;
      #64;
   endtask

   // One frame; the link clock runs only while selected
   task automatic frame(input int nb, input logic [12:0] ctl,
                        output logic [31:0] rx);
      cs_n = 1'b0;
      rx = 32'h0;
      #64;
      for (int k = 0; k < nb; k++) begin
         sdi = (k < 13) ? ctl[12-k] : ~sdi;
         #16 sck = 1'b1;
         rx = {rx[30:0], line};
         #16 sck = 1'b0;
      end
      cs_n = 1'b1;
      sdi = ~sdi;
      #48;
   endtask
endmodule

// [adc_serial_result_and_select_port_tb_top.sv]
// Self-checking bench for the serial result and select port
`timescale 1ns/1ps
module adc_serial_result_and_select_port_tb_top;
   logic             core_clk;
   logic             srst;
   logic             cs_n;
   logic             sck;
   logic             sdi;
   logic             sro;
   logic             oe;
   logic             conv_done;
   adc_pkg::result_t conv_result;
   logic             start;
   logic             busy;
   logic [2:0]       pos;
   logic [2:0]       neg;
   logic [15:0]      osr;
   logic             dbl;
   logic [7:0]       cnt_q;
   logic [31:0]      core_rnd;
   logic [2:0]       e_pos;
   logic [2:0]       e_neg;
   logic [15:0]      e_osr;
   logic             e_dbl;
   int               n_starts;
   int               cycles;
   int               n_fail;
   int               total_checks;

   adc_serial_port u_adc_serial_port (
      .core_clk(core_clk), .srst(srst), .sck(sck), .cs_n(cs_n),
      .sdi(sdi), .serial_result_out(sro), .serial_result_oe(oe),
      .conv_done(conv_done), .conv_result(conv_result),
      .conv_start_q(start), .conv_busy_q(busy), .pos_input_q(pos),
      .neg_input_q(neg), .osr_ratio_q(osr), .double_rate_q(dbl)
   );

   spi_host_model u_spi_host_model (
      .cs_n(cs_n), .sck(sck), .sdi(sdi),
      .serial_result_out(sro), .serial_result_oe(oe)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Word layout: done low, filler low, then the result struct
   function automatic logic [31:0] word_of(input adc_pkg::result_t r);
      return {1'b0, 1'b0, r};
   endfunction

   function automatic logic [15:0] osr_of(input logic [3:0] c);
      return (c == 4'hf) ? 16'h8000 : 16'h0020 << c;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check_cfg();
      check("pos", pos, e_pos);
      check("neg", neg, e_neg);
      check("osr", osr, e_osr);
      check("dbl", dbl, e_dbl);
   endtask

   // Bounded wait for the end of the running conversion
   task automatic wait_idle();
      for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
         @(posedge core_clk);
         #1;
      end
      check("busy idle", busy, 1'b0);
   endtask

   // One host frame, then the start count and settings it leads to
   task automatic run_frame(input int nb, input logic [12:0] ctl);
      logic [31:0] rx;
      logic [31:0] e_word;
      int          s0;
      wait_idle();
      s0 = n_starts;
      e_word = word_of(conv_result);
      u_spi_host_model.frame(nb, ctl, rx);
      repeat (4) @(posedge core_clk);
      #1;
      if (nb == 32) check("word", rx, e_word);
      else check("part word", rx, e_word >> (32 - nb));
      if (nb == 32 && ctl[12:10] == 3'h5) begin
         e_pos = {1'b0, ctl[5], ctl[8]};
         e_neg = ctl[9] ? 3'h4 : {1'b0, ctl[5], ~ctl[8]};
         if (ctl[4:1] != 4'h0) begin
            e_osr = osr_of(ctl[4:1]);
            e_dbl = ctl[0];
         end
      end
      check("starts", n_starts, s0 + 1);
      check("busy run", busy, 1'b1);
      check_cfg();
      $display("test frame of %0d bits done", nb);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Converter stand-in: each conversion ends after a random wait
   always @(posedge core_clk) begin
      core_rnd <= lfsr(core_rnd);
      cycles <= cycles + 1;
      if (start) n_starts <= n_starts + 1;
      if (srst || start) cnt_q <= srst ? 8'h0 : 8'h14 + {2'h0, core_rnd[5:0]};
      else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
      conv_done <= (cnt_q == 8'h1) && !start && !srst;
      if (cnt_q == 8'h1) conv_result <= core_rnd[29:0];
      if (cycles == 20000) begin
         n_fail++;
         wrap_up();
      end
   end

   initial begin
      logic [31:0] rnd;
      logic [12:0] ctl;
      logic [3:0]  code;
      rnd = 32'h714a;
      core_rnd = 32'h714a;
      srst = 1'b1;
      conv_done = 1'b0;
      conv_result = 30'h0;
      cnt_q = 8'h0;
      {e_pos, e_neg, e_osr, e_dbl} = {3'h0, 3'h1, 16'h0100, 1'b0};
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check_cfg();
      // Done flag while converting, then low once the result is ready
      u_spi_host_model.select(1'b1);
      check("flag busy", u_spi_host_model.line, 1'b1);
      wait_idle();
      repeat (3) @(posedge core_clk);
      check("flag done", u_spi_host_model.line, 1'b0);
      u_spi_host_model.select(1'b0);
      check("oe idle", oe, 1'b0);
      $display("test done flag done");
      // Speed codes 1 to 9 and 15, a keep code, then prefixes 100 and 000
      for (int i = 0; i < 13; i++) begin
         rnd = lfsr(rnd);
         code = (i < 9) ? 4'(i + 1) : (i == 9) ? 4'hf : 4'h0;
         ctl = {3'h5, rnd[1:0], 2'h0, rnd[2], code, rnd[3]};
         if (i >= 11) ctl[12:10] = (i == 11) ? 3'h4 : 3'h0;
         run_frame(32, ctl);
      end
      // Abort after ten bits: update refused, new conversion begins
      run_frame(10, {3'h5, 10'h3ff});
      wrap_up();
   end
endmodule
